// >>> rtl/rsi_reset_init.sv
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rsi_map.svh"
// Summary of operation
// - Core clock enable stays off while reset is held and during loading.
// - Crystal main and sub oscillators halt; their pins become port I/O in reset.
// - External main and sub clock inputs ignored in reset; pins become port I/O.
// - Program counter loads the 16-bit vector from addresses 0000h and 0001h.
// - Port output latches clear to zero.
// - Port direction registers set to all ones: every pin an input.
// - Pull-up enable registers clear to zero.
// - Expansion RAM size becomes 0x0c, memory size 0xcf, any capacity.
// - Memory bank select clears to zero.
// - Clock operation mode select clears to zero.
// - Stabilisation time select loads 5.
// - Stabilisation counter status clears to zero.
// - Both 16-bit timer counters clear to zero.
// - All four 16-bit capture/compare registers clear to zero.
// - Both 16-bit timer mode registers clear to zero.
// - Both 16-bit timer prescaler registers clear to zero.
// - Both capture/compare control registers clear to zero.
// - Both timer output control registers clear to zero.
// - Fast and slow internal oscillators stop; execution resumes on fast osc.
// - Pin, watchdog, power-on-clear and voltage detector resets act identically once the pin's low time has qualified.
module rsi_reset_init
   import rsi_pkg::*;
#(
   parameter int EXT_MIN_CYC = `RSI_EXT_MIN_CYC
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        reset_pin_n,
   input  wire logic        watchdog_overflow,
   input  wire logic        power_on_clear_det,
   input  wire logic        low_voltage_detector_det,
   input  wire logic [7:0]  vector_lo,
   input  wire logic [7:0]  vector_hi,
   output logic             core_clk_en,
   output logic             crystal_main_osc_en,
   output logic             crystal_sub_osc_en,
   output logic             ext_main_clk_accept,
   output logic             ext_sub_clk_accept,
   output logic             clk_pins_port_mode,
   output logic             internal_fast_osc_en,
   output logic             internal_slow_osc_en,
   output logic             power_on_clear_en,
   output logic             low_voltage_detector_en,
   output logic             cpu_on_fast_osc,
   output logic             reset_status_output_bit,
   output logic [15:0]      program_counter,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hsel,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);

   // ****************************************
   // Reset source synchronisation
   // ****************************************
   logic [3:0] src_raw;
   logic [3:0] src_sync;
   // All sources map to one request; only the pin is first qualified by its low time
   assign src_raw = {~reset_pin_n, watchdog_overflow, power_on_clear_det,
                     low_voltage_detector_det};

   rsi_sync #(.W(4)) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (src_raw),
      .q      (src_sync)
   );

   wire ext_low = src_sync[3];
   wire int_req = |src_sync[2:0];

   // ****************************************
   // Pin low-time qualification
   // ****************************************
   // Glitches shorter than the minimum low time are not taken as a reset
   logic [15:0] low_cnt_reg;
   logic        ext_req;
   wire  [15:0] min_cnt = 16'(EXT_MIN_CYC);
   assign ext_req = ext_low && (low_cnt_reg >= min_cnt);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_reg <= 16'h0000;
      end else if (!ext_low) begin
         low_cnt_reg <= 16'h0000;
      end else if (low_cnt_reg < min_cnt) begin
         low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
   end

   wire reset_req = ext_req || int_req;

   // ****************************************
   // Sequencer
   // ****************************************
   rsi_state_t state_reg;
   rsi_state_t state_next;
   logic [1:0] load_cnt_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         RSI_HELD: if (!reset_req) state_next = RSI_LOAD;
         RSI_LOAD: begin
            if (reset_req) begin
               state_next = RSI_HELD;
            end else if (load_cnt_reg == 2'(`RSI_LOAD_CYC - 1)) begin
               state_next = RSI_RUN;
            end
         end
         RSI_RUN:  if (reset_req) state_next = RSI_HELD;
         default: state_next = RSI_HELD;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg    <= RSI_HELD;
         load_cnt_reg <= 2'h0;
      end else begin
         state_reg    <= state_next;
         load_cnt_reg <= (state_reg == RSI_LOAD) ? load_cnt_reg + 2'h1 : 2'h0;
      end
   end

   wire in_reset = (state_reg == RSI_HELD);
   wire running  = (state_reg == RSI_RUN);
   wire init_now = in_reset;

   // ****************************************
   // Clock and oscillator gating
   // ****************************************
   logic main_osc_on_reg;
   logic sub_osc_on_reg;

   assign core_clk_en             = running;
   assign crystal_main_osc_en     = !in_reset && main_osc_on_reg;
   assign crystal_sub_osc_en      = !in_reset && sub_osc_on_reg;
   assign ext_main_clk_accept     = !in_reset && main_osc_on_reg;
   assign ext_sub_clk_accept      = !in_reset && sub_osc_on_reg;
   assign clk_pins_port_mode      = in_reset;
   assign internal_fast_osc_en    = !in_reset;
   assign internal_slow_osc_en    = !in_reset;
   assign power_on_clear_en       = 1'b1;
   assign low_voltage_detector_en = !in_reset;

   // ****************************************
   // Bus address and data phase
   // ****************************************
   logic [11:0] addr_reg;
   logic        wr_pend_reg;
   logic        rd_pend_reg;
   wire  take  = hsel && hready && htrans[1];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_reg    <= 12'h000;
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
      end else begin
         if (take) addr_reg <= haddr;
         wr_pend_reg <= take && hwrite;
         rd_pend_reg <= take && !hwrite;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   function automatic logic wsel(input logic [11:0] off);
      return wr_pend_reg && (addr_reg == off);
   endfunction

   // ****************************************
   // Initialised registers
   // ****************************************
   logic [7:0]  psw_reg, port_lat_reg, port_dir_reg, pullup_reg;
   logic [7:0]  ixs_reg, ims_reg, bank_reg, clock_operation_mode_reg_reg;
   logic [7:0]  pcc_reg, rcm_reg, moc_reg, mcm_reg;
   logic [7:0]  stabilization_time_select_reg_reg, stabilization_counter_status_reg_reg;
   logic [15:0] tmr_cnt_reg [2];
   logic [15:0] tmr_cc_reg  [4];
   logic [7:0]  tmr_mode_reg [2];
   logic [7:0]  tmr_prm_reg  [2];
   logic [7:0]  tmr_crc_reg  [2];
   logic [7:0]  tmr_toc_reg  [2];
   logic [15:0] pc_reg;
   logic        reset_status_output_bit_reg;

   // Reset vector is fetched on every cycle of reset and loading; value final when the core enters run
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_reg <= 16'h0000;
      end else if (!running) begin
         pc_reg <= {vector_hi, vector_lo};
      end
   end
   assign program_counter = pc_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         psw_reg      <= `RSI_RST_PSW;
         port_lat_reg <= `RSI_RST_PORT_LAT;
         port_dir_reg <= `RSI_RST_PORT_DIR;
         pullup_reg   <= `RSI_RST_PULLUP;
         ixs_reg      <= `RSI_RST_IXS;
         ims_reg      <= `RSI_RST_IMS;
         bank_reg     <= `RSI_RST_BANK;
         clock_operation_mode_reg_reg   <= `RSI_RST_CLOCK_OPERATION_MODE_REG;
         pcc_reg      <= `RSI_RST_PCC;
         rcm_reg      <= `RSI_RST_RCM;
         moc_reg      <= `RSI_RST_MOC;
         mcm_reg      <= `RSI_RST_MCM;
         stabilization_time_select_reg_reg     <= `RSI_RST_STABILIZATION_TIME_SELECT_REG;
         stabilization_counter_status_reg_reg     <= `RSI_RST_STABILIZATION_COUNTER_STATUS_REG;
      end else if (init_now) begin
         psw_reg      <= `RSI_RST_PSW;
         port_lat_reg <= `RSI_RST_PORT_LAT;
         port_dir_reg <= `RSI_RST_PORT_DIR;
         pullup_reg   <= `RSI_RST_PULLUP;
         ixs_reg      <= `RSI_RST_IXS;
         ims_reg      <= `RSI_RST_IMS;
         bank_reg     <= `RSI_RST_BANK;
         clock_operation_mode_reg_reg   <= `RSI_RST_CLOCK_OPERATION_MODE_REG;
         pcc_reg      <= `RSI_RST_PCC;
         rcm_reg      <= `RSI_RST_RCM;
         moc_reg      <= `RSI_RST_MOC;
         mcm_reg      <= `RSI_RST_MCM;
         stabilization_time_select_reg_reg     <= `RSI_RST_STABILIZATION_TIME_SELECT_REG;
         stabilization_counter_status_reg_reg     <= `RSI_RST_STABILIZATION_COUNTER_STATUS_REG;
      end else begin
         if (wsel(`RSI_OFF_PSW))      psw_reg      <= hwdata[7:0];
         if (wsel(`RSI_OFF_PORT_LAT)) port_lat_reg <= hwdata[7:0];
         if (wsel(`RSI_OFF_PORT_DIR)) port_dir_reg <= hwdata[7:0];
         if (wsel(`RSI_OFF_PULLUP))   pullup_reg   <= hwdata[7:0];
         if (wsel(`RSI_OFF_MEMSIZE)) begin
            ixs_reg  <= hwdata[7:0];
            ims_reg  <= hwdata[15:8];
            bank_reg <= hwdata[23:16];
         end
         if (wsel(`RSI_OFF_CLKCFG)) begin
            clock_operation_mode_reg_reg <= hwdata[7:0];
            pcc_reg    <= hwdata[15:8];
            rcm_reg    <= hwdata[23:16];
            moc_reg    <= hwdata[31:24];
         end
         if (wsel(`RSI_OFF_OSCMISC))  mcm_reg      <= hwdata[7:0];
         if (wsel(`RSI_OFF_STAB)) begin
            stabilization_time_select_reg_reg <= hwdata[7:0];
            stabilization_counter_status_reg_reg <= hwdata[15:8];
         end
      end
   end

   // Main oscillator runs only when software clears the stop bit (bit 7); sub oscillator when it sets bit 4
   assign main_osc_on_reg = !moc_reg[7];
   assign sub_osc_on_reg  = clock_operation_mode_reg_reg[4];

   // ****************************************
   // Two 16-bit timer register sets
   // ****************************************
   genvar t;
   generate
      for (t = 0; t < 2; t++) begin : g_tmr
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               tmr_cnt_reg[t]      <= `RSI_RST_T16;
               tmr_cc_reg[2*t]     <= `RSI_RST_T16;
               tmr_cc_reg[2*t+1]   <= `RSI_RST_T16;
               tmr_mode_reg[t]     <= `RSI_RST_T8;
               tmr_prm_reg[t]      <= `RSI_RST_T8;
               tmr_crc_reg[t]      <= `RSI_RST_T8;
               tmr_toc_reg[t]      <= `RSI_RST_T8;
            end else if (init_now) begin
               tmr_cnt_reg[t]      <= `RSI_RST_T16;
               tmr_cc_reg[2*t]     <= `RSI_RST_T16;
               tmr_cc_reg[2*t+1]   <= `RSI_RST_T16;
               tmr_mode_reg[t]     <= `RSI_RST_T8;
               tmr_prm_reg[t]      <= `RSI_RST_T8;
               tmr_crc_reg[t]      <= `RSI_RST_T8;
               tmr_toc_reg[t]      <= `RSI_RST_T8;
            end else begin
               if (wsel(`RSI_OFF_TMR_CNT)) tmr_cnt_reg[t] <= hwdata[16*t +: 16];
               if (wsel(t == 0 ? `RSI_OFF_TMR_CC0 : `RSI_OFF_TMR_CC1)) begin
                  tmr_cc_reg[2*t]   <= hwdata[15:0];
                  tmr_cc_reg[2*t+1] <= hwdata[31:16];
               end
               if (wsel(t == 0 ? `RSI_OFF_TMR_CTL0 : `RSI_OFF_TMR_CTL1)) begin
                  tmr_mode_reg[t] <= hwdata[7:0];
                  tmr_prm_reg[t]  <= hwdata[15:8];
                  tmr_crc_reg[t]  <= hwdata[23:16];
                  tmr_toc_reg[t]  <= hwdata[31:24];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Reset-status pin
   // ****************************************
   // Held low from reset until software releases it; not cleared by writing 0
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reset_status_output_bit_reg <= 1'b0;
      end else if (in_reset) begin
         reset_status_output_bit_reg <= 1'b0;
      end else if (wsel(`RSI_OFF_CTRL) && hwdata[`RSI_CTRL_RESET_STATUS_OUTPUT_BIT_BIT]) begin
         reset_status_output_bit_reg <= 1'b1;
      end
   end
   assign reset_status_output_bit = reset_status_output_bit_reg;

   // After release the core always starts on the fast internal oscillator
   assign cpu_on_fast_osc = running && (mcm_reg[0] == 1'b0);

   // ****************************************
   // Read data
   // ****************************************
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_reg)
         `RSI_OFF_CTRL:     rd_mux = {31'h0, reset_status_output_bit_reg};
         `RSI_OFF_STATUS:   rd_mux = {29'h0, reset_status_output_bit_reg, in_reset, running};
         `RSI_OFF_PC:       rd_mux = {16'h0, pc_reg};
         `RSI_OFF_PSW:      rd_mux = {24'h0, psw_reg};
         `RSI_OFF_PORT_LAT: rd_mux = {24'h0, port_lat_reg};
         `RSI_OFF_PORT_DIR: rd_mux = {24'h0, port_dir_reg};
         `RSI_OFF_PULLUP:   rd_mux = {24'h0, pullup_reg};
         `RSI_OFF_MEMSIZE:  rd_mux = {8'h0, bank_reg, ims_reg, ixs_reg};
         `RSI_OFF_CLKCFG:   rd_mux = {moc_reg, rcm_reg, pcc_reg, clock_operation_mode_reg_reg};
         `RSI_OFF_OSCMISC:  rd_mux = {24'h0, mcm_reg};
         `RSI_OFF_STAB:     rd_mux = {16'h0, stabilization_counter_status_reg_reg, stabilization_time_select_reg_reg};
         `RSI_OFF_TMR_CNT:  rd_mux = {tmr_cnt_reg[1], tmr_cnt_reg[0]};
         `RSI_OFF_TMR_CC0:  rd_mux = {tmr_cc_reg[1], tmr_cc_reg[0]};
         `RSI_OFF_TMR_CC1:  rd_mux = {tmr_cc_reg[3], tmr_cc_reg[2]};
         `RSI_OFF_TMR_CTL0: rd_mux = {tmr_toc_reg[0], tmr_crc_reg[0],
                                      tmr_prm_reg[0], tmr_mode_reg[0]};
         `RSI_OFF_TMR_CTL1: rd_mux = {tmr_toc_reg[1], tmr_crc_reg[1],
                                      tmr_prm_reg[1], tmr_mode_reg[1]};
         `RSI_OFF_VECTOR:   rd_mux = {16'h0, vector_hi, vector_lo};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end
   assign hrdata = rd_pend_reg ? rd_mux : 32'h0000_0000;

   wire unused_ok = &{1'b0, hsize, htrans[0]};
endmodule : rsi_reset_init
`default_nettype wire

// >>> shared/rsi_map.svh
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define RSI_OFF_CTRL        12'h000
`define RSI_OFF_STATUS      12'h004
`define RSI_OFF_PC          12'h008
`define RSI_OFF_PSW         12'h00c
`define RSI_OFF_PORT_LAT    12'h010
`define RSI_OFF_PORT_DIR    12'h014
`define RSI_OFF_PULLUP      12'h018
`define RSI_OFF_MEMSIZE     12'h01c
`define RSI_OFF_CLKCFG      12'h020
`define RSI_OFF_OSCMISC     12'h024
`define RSI_OFF_STAB        12'h028
`define RSI_OFF_TMR_CNT     12'h02c
`define RSI_OFF_TMR_CC0     12'h030
`define RSI_OFF_TMR_CC1     12'h034
`define RSI_OFF_TMR_CTL0    12'h038
`define RSI_OFF_TMR_CTL1    12'h03c
`define RSI_OFF_VECTOR      12'h040

// ****************************************
// Reset values
// ****************************************
`define RSI_RST_PSW         8'h02
`define RSI_RST_PORT_LAT    8'h00
`define RSI_RST_PORT_DIR    8'hff
`define RSI_RST_PULLUP      8'h00
`define RSI_RST_IXS         8'h0c
`define RSI_RST_IMS         8'hcf
`define RSI_RST_BANK        8'h00
`define RSI_RST_CLOCK_OPERATION_MODE_REG      8'h00
`define RSI_RST_PCC         8'h01
`define RSI_RST_RCM         8'h80
`define RSI_RST_MOC         8'h80
`define RSI_RST_MCM         8'h00
`define RSI_RST_STABILIZATION_TIME_SELECT_REG        8'h05
`define RSI_RST_STABILIZATION_COUNTER_STATUS_REG        8'h00
`define RSI_RST_T16         16'h0000
`define RSI_RST_T8          8'h00

// ****************************************
// Field positions
// ****************************************
`define RSI_CTRL_RESET_STATUS_OUTPUT_BIT_BIT   0
`define RSI_ST_RUN_BIT      0
`define RSI_ST_HELD_BIT     1
`define RSI_ST_RESET_STATUS_OUTPUT_BIT_BIT     2

// ****************************************
// Timing
// ****************************************
`define RSI_CLK_MHZ         200
`define RSI_EXT_MIN_US      10
`define RSI_EXT_MIN_CYC     (`RSI_EXT_MIN_US * `RSI_CLK_MHZ)
`define RSI_LOAD_CYC        2

`endif

// >>> shared/rsi_pkg.sv
package rsi_pkg;
   typedef enum logic [2:0] {
      RSI_HELD  = 3'b001,
      RSI_LOAD  = 3'b010,
      RSI_RUN   = 3'b100
   } rsi_state_t;
endpackage : rsi_pkg

// >>> rtl/rsi_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser bank; first stage feeds only the second
module rsi_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_reg[i] <= 1'b0;
               q[i]        <= 1'b0;
            end else begin
               meta_reg[i] <= d[i];
               q[i]        <= meta_reg[i];
            end
         end
      end
   endgenerate
endmodule : rsi_sync
`default_nettype wire

// >>> tb/rsi_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Reset requesters: pin, watchdog, power-on-clear, voltage detector
// ****
module rsi_src_model import rsi_pkg::*; (
   input  wire logic clk,
   output logic      reset_pin_n,
   output logic      watchdog_overflow,
   output logic      power_on_clear_det,
   output logic      low_voltage_detector_det
);
   initial begin
      reset_pin_n = 1'b1;
      watchdog_overflow = 1'b0;
      power_on_clear_det = 1'b0;
      low_voltage_detector_det = 1'b0;
   end
   // Holds one source for len cycles; short pin pulses model glitches
   task automatic fire(input int kind, input int len);
      @(posedge clk);
      case (kind)
         0: reset_pin_n <= 1'b0;
         1: watchdog_overflow <= 1'b1;
         2: power_on_clear_det <= 1'b1;
         default: low_voltage_detector_det <= 1'b1;
      endcase
      repeat (len) @(posedge clk);
      reset_pin_n <= 1'b1;
      watchdog_overflow <= 1'b0;
      power_on_clear_det <= 1'b0;
      low_voltage_detector_det <= 1'b0;
   endtask : fire
endmodule : rsi_src_model
`default_nettype wire

// >>> tb/rsi_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Reset sequencing checks
// ****
module rsi_chk import rsi_pkg::*; (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        watchdog_overflow,
   input wire logic        power_on_clear_det,
   input wire logic        low_voltage_detector_det,
   input wire logic [7:0]  vector_lo,
   input wire logic [7:0]  vector_hi,
   input wire logic        core_clk_en,
   input wire logic        crystal_main_osc_en,
   input wire logic        crystal_sub_osc_en,
   input wire logic        ext_main_clk_accept,
   input wire logic        ext_sub_clk_accept,
   input wire logic        clk_pins_port_mode,
   input wire logic        internal_fast_osc_en,
   input wire logic        internal_slow_osc_en,
   input wire logic        power_on_clear_en,
   input wire logic        low_voltage_detector_en,
   input wire logic        cpu_on_fast_osc,
   input wire logic        reset_status_output_bit,
   input wire logic [15:0] program_counter,
   input wire logic [11:0] haddr,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence src_hit;
      $rose(watchdog_overflow) || $rose(power_on_clear_det) || $rose(low_voltage_detector_det);
   endsequence
   sequence load_run;
      !core_clk_en [*2] ##1 core_clk_en;
   endsequence
   clk_gate_a: assert property (clk_pins_port_mode |-> !core_clk_en
      && !crystal_main_osc_en && !crystal_sub_osc_en) else $error("clock live in reset");
   ext_clk_a: assert property (clk_pins_port_mode |->
      !ext_main_clk_accept && !ext_sub_clk_accept) else $error("external clock accepted");
   int_osc_a: assert property (clk_pins_port_mode |-> !internal_fast_osc_en
      && !internal_slow_osc_en && !low_voltage_detector_en) else $error("oscillator live");
   poc_on_a: assert property (power_on_clear_en) else $error("power-on-clear off");
   src_reset_a: assert property (src_hit |-> ##[1:4] clk_pins_port_mode)
      else $error("internal source ignored");
   load_time_a: assert property ($fell(clk_pins_port_mode) |-> load_run)
      else $error("load phase length wrong");
   pc_load_a: assert property ($rose(core_clk_en) |->
      program_counter == {$past(vector_hi), $past(vector_lo)}) else $error("vector not loaded");
   fast_osc_a: assert property ($rose(core_clk_en) |-> cpu_on_fast_osc
      && internal_fast_osc_en) else $error("not resumed on fast oscillator");
   status_pin_a: assert property ($rose(reset_status_output_bit) |-> $past(hwdata[0])
      && $past(hwrite, 2) && $past(haddr, 2) == 12'h000) else $error("status pin rose alone");
endmodule : rsi_chk
bind rsi_reset_init rsi_chk rsi_chk_inst (.clk, .arst_n, .watchdog_overflow,
   .power_on_clear_det, .low_voltage_detector_det, .vector_lo, .vector_hi, .core_clk_en,
   .crystal_main_osc_en, .crystal_sub_osc_en, .ext_main_clk_accept, .ext_sub_clk_accept,
   .clk_pins_port_mode, .internal_fast_osc_en, .internal_slow_osc_en, .power_on_clear_en,
   .low_voltage_detector_en, .cpu_on_fast_osc, .reset_status_output_bit, .program_counter,
   .haddr, .hwrite, .hwdata);
`default_nettype wire

// >>> tb/reset_state_initializer_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module reset_state_initializer_bench import rsi_pkg::*;;
   logic        clk, arst_n, reset_pin_n, watchdog_overflow, power_on_clear_det;
   logic        low_voltage_detector_det, core_clk_en, crystal_main_osc_en, crystal_sub_osc_en;
   logic        ext_main_clk_accept, ext_sub_clk_accept, clk_pins_port_mode, hresp;
   logic        internal_fast_osc_en, internal_slow_osc_en, power_on_clear_en, hwrite, hsel;
   logic        low_voltage_detector_en, cpu_on_fast_osc, reset_status_output_bit, hreadyout;
   logic [7:0]  vector_lo, vector_hi;
   logic [15:0] program_counter, v;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   int          error_cnt, samples_checked, cyc;
   logic [11:0] ofs [13] = '{12'h00c, 12'h01c, 12'h020, 12'h024, 12'h028, 12'h010, 12'h014,
                             12'h018, 12'h02c, 12'h030, 12'h034, 12'h038, 12'h03c};
   logic [31:0] ev [13] = '{32'h02, 32'hcf0c, 32'h80800100, 32'h0, 32'h05, 32'h0, 32'hff,
                            32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   rsi_src_model rsi_src_model_inst (.clk, .reset_pin_n, .watchdog_overflow,
      .power_on_clear_det, .low_voltage_detector_det);
   rsi_reset_init #(.EXT_MIN_CYC(8)) rsi_reset_init_inst (.clk, .arst_n, .reset_pin_n,
      .watchdog_overflow, .power_on_clear_det, .low_voltage_detector_det, .vector_lo,
      .vector_hi, .core_clk_en, .crystal_main_osc_en, .crystal_sub_osc_en, .ext_main_clk_accept,
      .ext_sub_clk_accept, .clk_pins_port_mode, .internal_fast_osc_en, .internal_slow_osc_en,
      .power_on_clear_en, .low_voltage_detector_en, .cpu_on_fast_osc, .reset_status_output_bit,
      .program_counter, .haddr, .htrans, .hwrite, .hsize, .hsel, .hready(hreadyout), .hwdata,
      .hrdata, .hreadyout, .hresp);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task summarize;
      $display("errors=%0d checks=%0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         summarize;
      end
   end
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : bus
   task wait_run;
      int n;
      n = 0;
      while (core_clk_en !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK({cpu_on_fast_osc, internal_fast_osc_en}, 2'h3)
      `CHK({internal_slow_osc_en, low_voltage_detector_en, hresp}, 3'h6)
   endtask : wait_run
   task t_in_reset;
      `CHK({core_clk_en, crystal_main_osc_en, crystal_sub_osc_en}, 3'h0)
      `CHK({ext_main_clk_accept, ext_sub_clk_accept, clk_pins_port_mode}, 3'h1)
      `CHK({internal_fast_osc_en, internal_slow_osc_en}, 2'h0)
      `CHK({low_voltage_detector_en, power_on_clear_en}, 2'h1)
   endtask : t_in_reset
   // The status pin updates at the edge that ends the data phase
   task t_status_pin;
      bus(1'b1, 12'h000, 32'h0);
      @(posedge clk);
      `CHK(reset_status_output_bit, 1'b0)
      bus(1'b1, 12'h000, 32'h1);
      @(posedge clk);
      `CHK(reset_status_output_bit, 1'b1)
   endtask : t_status_pin
   task t_short_pin;
      rsi_src_model_inst.fire(0, 4);
      repeat (8) @(posedge clk);
      `CHK({core_clk_en, reset_status_output_bit}, 2'h3)
   endtask : t_short_pin
   task t_regs(input int src);
      for (int i = 0; i < 13; i++) bus(1'b1, ofs[i], 32'hffffffff);
      bus(1'b0, 12'h00c, 32'h0);
      `CHK(rd, 32'hff)
      `CHK({crystal_main_osc_en, crystal_sub_osc_en}, 2'h1)
      `CHK({ext_main_clk_accept, ext_sub_clk_accept}, 2'h1)
      `CHK(cpu_on_fast_osc, 1'b0)
      bus(1'b1, 12'h000, 32'h1);
      v = 16'ha5c0 ^ 16'(src);
      vector_hi <= v[15:8];
      vector_lo <= v[7:0];
      rsi_src_model_inst.fire(src, 14);
      t_in_reset;
      wait_run;
      `CHK(program_counter, v)
      bus(1'b0, 12'h004, 32'h0);
      `CHK(rd, 32'h1)
      for (int i = 0; i < 13; i++) begin
         bus(1'b0, ofs[i], 32'h0);
         if (i < 5) `CHK(rd, ev[i])
         else `CHK(rd, ev[i])
      end
   endtask : t_regs
   initial begin
      {arst_n, hwrite, hsel, haddr, htrans, hwdata, error_cnt, samples_checked, cyc} = '0;
      {vector_hi, vector_lo} = 16'h1234;
      hsize = 3'b010;
      repeat (2) @(posedge clk);
      t_in_reset;
      arst_n <= 1'b1;
      wait_run;
      t_status_pin;
      t_short_pin;
      for (int s = 0; s < 4; s++) t_regs(s);
      bus(1'b0, 12'h080, 32'h0);
      `CHK(rd, 32'h0)
      summarize;
   end
endmodule : reset_state_initializer_bench
`default_nettype wire
